// ===== logic/eacbu_core.sv
/*
  Extended-address conditional branch unit: decodes the greater-than,
  less-or-equal and less-than branch forms, decides the outcome, forms
  the next program counter and paces completion per configuration.
  Assumes decode presents operands already read from the register file,
  the prefix state of the directly preceding instruction and any
  prediction, all synchronous to pclk. Registers sit on an APB slave.
*/
// Function
// (RULE1) Greater-than forms branch only when the source value is above zero.
// (RULE2) Less-or-equal forms branch only when the source is zero or below.
// (RULE3) Less-than forms branch only when the source value is below zero.
// (RULE4) Register form target is current PC plus full offset register.
// (RULE5) Immediate form target is PC plus immediate, widened by a prefix.
// (RULE6) A false condition steps the program counter by four.
// (RULE7) Register form compares long value when long flag set, else 32 bits.
// (RULE8) Immediate form compares long only after a long prefix.
// (RULE9) Delay-slot flag lets the following instruction complete first.
// (RULE10) Without delay slot the target runs next; follower is squashed.
// (RULE11) Without prefix the 16-bit immediate is sign-extended to 64 bits.
// (RULE12) A directly preceding prefix replaces the default offset.
// (RULE13) Not-taken or correctly predicted immediate branch takes one cycle.
// (RULE14) Taken with delay slot takes two cycles unless area setting is two.
// (RULE15) Taken without slot takes three; area zero mispredict also three.
// (RULE16) Area setting two: taken with delay slot takes six cycles.
// (RULE17) Area setting two: taken without slot or mispredict takes seven.
// (RULE18) Area two register form adds two cycles when translation level above one.
// (RULE19) Fields: source at bits 11-15, offset from bit 16, MSB-first numbering.
// (RULE20) Comparisons are signed two's complement; only the PC changes.
`timescale 1ns/1ps

module eacbu_core
  import eacbu_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Branch request from decode
  input wire logic req_valid,
  input wire eacbu_req_s req,
  output logic req_ready,
  // Result to program counter and fetch
  output logic res_done,
  output eacbu_res_s res
);

  eacbu_state_s q;
  eacbu_state_s next_q;

  // Decode of the presented instruction
  logic [5:0] opc;
  logic [2:0] cond;
  logic is_reg_form;
  logic is_imm_form;
  logic cond_known;
  logic long_cmp;
  logic signed [63:0] cmp_val;
  logic [63:0] imm_off;
  logic [63:0] offset;
  logic cond_true;
  logic predicted_ok;
  logic missed;
  logic [3:0] lat;
  logic accept;
  eacbu_res_s new_res;

  always_comb begin
    opc = req.instr[OPC_HI:OPC_LO];
    cond = req.instr[COND_HI:COND_LO];
    // MSB-first bits 0-5 opcode, 11-15 source, 16 onward offset or immediate
    is_reg_form = (opc == OPC_REG_FORM); // [RULE19]
    is_imm_form = (opc == OPC_IMM_FORM); // [RULE19]
    cond_known = req.instr[EXT_BIT] &&
                 (cond == COND_GT || cond == COND_LE || cond == COND_LT);

    // Width of the compare
    if (is_reg_form) begin
      long_cmp = req.instr[LONG_BIT]; // [RULE7]
    end else begin
      long_cmp = req.pfx_valid && req.pfx_long; // [RULE8]
    end
    if (long_cmp) begin
      cmp_val = signed'(req.src_val);
    end else begin
      cmp_val = 64'(signed'(req.src_val[31:0])); // [RULE20]
    end

    // Offset formation
    if (req.pfx_valid && req.pfx_long) begin
      imm_off = {req.pfx_value, req.instr[IMM_HI:IMM_LO]}; // [RULE12]
    end else if (req.pfx_valid) begin
      imm_off = {{32{req.pfx_value[15]}}, req.pfx_value[15:0],
                 req.instr[IMM_HI:IMM_LO]}; // [RULE12]
    end else begin
      imm_off = {{48{req.instr[IMM_HI]}}, req.instr[IMM_HI:IMM_LO]}; // [RULE11]
    end
    offset = is_reg_form ? req.off_val : imm_off; // [RULE4] [RULE5]

    // Condition against zero, signed
    unique case (cond)
      COND_GT: cond_true = (cmp_val > 64'sh0); // [RULE1]
      COND_LE: cond_true = (cmp_val <= 64'sh0); // [RULE2]
      COND_LT: cond_true = (cmp_val < 64'sh0); // [RULE3]
      default: cond_true = 1'b0;
    endcase

    // Prediction only exists for the immediate form
    predicted_ok = is_imm_form && req.pred_valid && (req.pred_taken == cond_true);
    missed = is_imm_form && req.pred_valid && (req.pred_taken != cond_true);

    // Cycle count; a correct prediction hides the redirect entirely
    if (predicted_ok || (!cond_true && !missed)) begin
      lat = LAT_SHORT; // [RULE13]
    end else if (q.area_speed_setting == AREA_SLOW) begin
      if (cond_true && req.instr[DS_BIT]) begin
        lat = LAT_TAKEN_DS_SLOW; // [RULE16]
      end else begin
        lat = LAT_TAKEN_NODS_SLOW; // [RULE17]
      end
      if (is_reg_form && q.translation_unit_level > XLATE_LEVEL_LIMIT) begin
        lat = lat + LAT_XLATE_EXTRA; // [RULE18]
      end
    end else if (cond_true) begin
      // Area settings zero, one and three
      lat = req.instr[DS_BIT] ? LAT_TAKEN_DS : LAT_TAKEN_NODS; // [RULE14] [RULE15]
    end else if (q.area_speed_setting == AREA_FAST) begin
      lat = LAT_MISS_FAST; // [RULE15]
    end else begin
      // Area settings one and three mispredict: same cost as a taken branch without slot
      lat = LAT_TAKEN_NODS;
    end

    new_res = '0;
    new_res.hit = (is_reg_form || is_imm_form) && cond_known;
    new_res.taken = new_res.hit && cond_true;
    new_res.delay_slot = new_res.taken && req.instr[DS_BIT]; // [RULE9]
    new_res.squash_next = new_res.taken && !req.instr[DS_BIT]; // [RULE10]
    new_res.mispredict = new_res.hit && missed;
    if (new_res.taken) begin
      new_res.next_pc = req.pc + offset; // [RULE4] [RULE5] [RULE20]
    end else begin
      new_res.next_pc = req.pc + SEQ_STEP; // [RULE6]
    end
    // Instructions that are not ours complete at once, untouched
    new_res.latency = new_res.hit ? lat : LAT_SHORT;
  end

  assign accept = req_valid && q.ready;

  // Next state
  always_comb begin
    next_q = q;
    next_q.done = 1'b0;

    unique case (q.fsm)
      ST_IDLE: begin
        if (accept) begin
          next_q.res = new_res;
          if (new_res.hit) begin
            next_q.branch_cnt = q.branch_cnt + 32'h1;
            if (new_res.taken) begin
              next_q.taken_cnt = q.taken_cnt + 32'h1;
            end
          end
          if (new_res.latency == LAT_SHORT) begin
            next_q.done = 1'b1; // [RULE13]
          end else begin
            next_q.fsm = ST_WAIT;
            next_q.ready = 1'b0;
            next_q.cnt = new_res.latency - 4'h2;
          end
        end
      end
      ST_WAIT: begin
        // Holds decode off so the measured cycle count is exact
        if (q.cnt == 4'h0) begin
          next_q.fsm = ST_IDLE;
          next_q.done = 1'b1; // [RULE14] [RULE15] [RULE16] [RULE17]
          next_q.ready = q.enable;
        end else begin
          next_q.cnt = q.cnt - 4'h1;
        end
      end
    endcase

    if (q.fsm == ST_IDLE && !accept) begin
      next_q.ready = q.enable;
    end

    // APB: no wait state, answer registered from the setup cycle
    next_q.apb = '0;
    if (psel && !penable) begin
      next_q.apb.pready = 1'b1;
      unique case (paddr)
        CTRL_ADDR: begin
          next_q.apb.prdata[CTRL_EN_BIT] = q.enable;
          next_q.apb.prdata[CTRL_AREA_LO +: 2] = q.area_speed_setting;
          next_q.apb.prdata[CTRL_XLATE_LO +: 2] = q.translation_unit_level;
        end
        STATUS_ADDR: begin
          next_q.apb.prdata[0] = (q.fsm == ST_WAIT);
          next_q.apb.prdata[1] = q.res.taken;
          next_q.apb.prdata[2] = q.res.delay_slot;
          next_q.apb.prdata[3] = q.res.mispredict;
          next_q.apb.prdata[4] = q.res.hit;
          next_q.apb.prdata[11:8] = q.res.latency;
        end
        BRANCH_CNT_ADDR: next_q.apb.prdata = q.branch_cnt;
        TAKEN_CNT_ADDR: next_q.apb.prdata = q.taken_cnt;
        TARGET_LO_ADDR: next_q.apb.prdata = q.res.next_pc[31:0];
        TARGET_HI_ADDR: next_q.apb.prdata = q.res.next_pc[63:32];
        default: next_q.apb.pslverr = 1'b1;
      endcase
      // Writes to read-only words are refused as well
      if (pwrite && paddr != CTRL_ADDR && paddr != BRANCH_CNT_ADDR &&
          paddr != TAKEN_CNT_ADDR) begin
        next_q.apb.pslverr = 1'b1;
      end
      if (pwrite) begin
        next_q.apb.prdata = '0;
      end
    end

    // Write takes effect at the completing edge only
    if (psel && penable && q.apb.pready && pwrite && !q.apb.pslverr) begin
      unique case (paddr)
        CTRL_ADDR: begin
          next_q.enable = pwdata[CTRL_EN_BIT];
          next_q.area_speed_setting = pwdata[CTRL_AREA_LO +: 2];
          next_q.translation_unit_level = pwdata[CTRL_XLATE_LO +: 2];
        end
        // Any write clears a counter; a branch counted in the same cycle survives
        BRANCH_CNT_ADDR: next_q.branch_cnt = {31'h0, next_q.branch_cnt != q.branch_cnt};
        TAKEN_CNT_ADDR: next_q.taken_cnt = {31'h0, next_q.taken_cnt != q.taken_cnt};
        default: next_q.enable = q.enable;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
      q.fsm <= ST_IDLE;
      q.enable <= CTRL_EN_RST;
      q.area_speed_setting <= AREA_RST;
      q.translation_unit_level <= XLATE_RST;
    end else begin
      q <= next_q;
    end
  end

  assign prdata = q.apb.prdata;
  assign pready = q.apb.pready;
  assign pslverr = q.apb.pslverr;
  assign req_ready = q.ready;
  assign res_done = q.done;
  assign res = q.res;

endmodule

// ===== pkg/eacbu_pkg.sv
/*
  Package of the extended-address conditional branch unit: instruction
  field positions, opcodes, condition codes, cycle counts, register map
  and the structs that carry requests, results and module state.
  Assumes a 32-bit instruction word and 64-bit registers and addresses.
*/
package eacbu_pkg;

  // Instruction fields, little-endian indices of the 32-bit word
  localparam int OPC_HI = 31;
  localparam int OPC_LO = 26;
  localparam int DS_BIT = 25;
  localparam int EXT_BIT = 24;
  localparam int COND_HI = 23;
  localparam int COND_LO = 21;
  localparam int SRC_HI = 20;
  localparam int SRC_LO = 16;
  localparam int OFF_HI = 15;
  localparam int OFF_LO = 11;
  localparam int LONG_BIT = 8;
  localparam int IMM_HI = 15;
  localparam int IMM_LO = 0;

  localparam logic [5:0] OPC_REG_FORM = 6'h27;
  localparam logic [5:0] OPC_IMM_FORM = 6'h2f;

  localparam logic [2:0] COND_GT = 3'h4;
  localparam logic [2:0] COND_LE = 3'h3;
  localparam logic [2:0] COND_LT = 3'h2;

  localparam logic [63:0] SEQ_STEP = 64'h0000_0000_0000_0004;

  // Cycle counts, area settings and translation level limit
  localparam logic [3:0] LAT_SHORT = 4'h1;
  localparam logic [3:0] LAT_TAKEN_DS = 4'h2;
  localparam logic [3:0] LAT_TAKEN_NODS = 4'h3;
  localparam logic [3:0] LAT_MISS_FAST = 4'h3;
  localparam logic [3:0] LAT_TAKEN_DS_SLOW = 4'h6;
  localparam logic [3:0] LAT_TAKEN_NODS_SLOW = 4'h7;
  localparam logic [3:0] LAT_XLATE_EXTRA = 4'h2;
  localparam logic [1:0] AREA_SLOW = 2'h2;
  localparam logic [1:0] AREA_FAST = 2'h0;
  localparam logic [1:0] XLATE_LEVEL_LIMIT = 2'h1;

  // Register map, byte addresses
  localparam logic [7:0] CTRL_ADDR = 8'h00;
  localparam logic [7:0] STATUS_ADDR = 8'h04;
  localparam logic [7:0] BRANCH_CNT_ADDR = 8'h08;
  localparam logic [7:0] TAKEN_CNT_ADDR = 8'h0c;
  localparam logic [7:0] TARGET_LO_ADDR = 8'h10;
  localparam logic [7:0] TARGET_HI_ADDR = 8'h14;

  // Control fields and reset values
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_AREA_LO = 4;
  localparam int CTRL_XLATE_LO = 8;
  localparam logic CTRL_EN_RST = 1'b1;
  localparam logic [1:0] AREA_RST = 2'h0;
  localparam logic [1:0] XLATE_RST = 2'h0;

  typedef enum logic [0:0] {
    ST_IDLE,
    ST_WAIT
  } eacbu_state_e;

  typedef struct packed {
    logic [31:0] instr;
    logic [63:0] pc;
    logic [63:0] src_val;
    logic [63:0] off_val;
    logic pfx_valid;
    logic pfx_long;
    logic [47:0] pfx_value;
    logic pred_valid;
    logic pred_taken;
  } eacbu_req_s;

  typedef struct packed {
    logic hit;
    logic taken;
    logic delay_slot;
    logic squash_next;
    logic mispredict;
    logic [63:0] next_pc;
    logic [3:0] latency;
  } eacbu_res_s;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } eacbu_apb_req_s;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } eacbu_apb_rsp_s;

  typedef struct packed {
    eacbu_state_e fsm;
    logic [3:0] cnt;
    logic ready;
    logic done;
    eacbu_res_s res;
    eacbu_apb_rsp_s apb;
    logic enable;
    logic [1:0] area_speed_setting;
    logic [1:0] translation_unit_level;
    logic [31:0] branch_cnt;
    logic [31:0] taken_cnt;
  } eacbu_state_s;

endpackage

// ===== bench/eacbu_core_properties.sv
/*
  Timing and outcome properties of the branch unit.
  Assumes it is bound to eacbu_core and sees only its ports.
*/
`timescale 1ns/1ps

module eacbu_core_chk
  import eacbu_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Branch request and result
  input wire logic req_valid,
  input wire eacbu_req_s req,
  input wire logic req_ready,
  input wire logic res_done,
  input wire eacbu_res_s res
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence take_s;
    req_valid && req_ready;
  endsequence

  chk_done_ready: assert property (
    res_done |-> req_ready) else $error("ready not back with done");
  chk_short_done: assert property (
    take_s |=> (res.latency == 4'h1) == res_done) else $error("one-cycle done wrong");
  chk_busy_refuse: assert property (
    take_s ##1 res.latency != 4'h1 |-> !req_ready) else $error("request taken while busy");
  chk_three_wait: assert property (
    take_s ##1 res.latency == 4'h3 |-> !res_done ##1 !res_done ##1 res_done)
    else $error("three-cycle done wrong");
  chk_seven_wait: assert property (
    take_s ##1 res.latency == 4'h7 |-> !res_done [*6] ##1 res_done)
    else $error("seven-cycle done wrong");
  chk_slot_lat: assert property (
    res_done && res.delay_slot |-> res.latency inside {4'h1, 4'h2, 4'h6, 4'h8})
    else $error("delay slot latency wrong");
  chk_squash_taken: assert property (
    res_done && res.squash_next |-> res.taken && !res.delay_slot)
    else $error("squash without taken branch");
  chk_untaken_fast: assert property (
    res_done && !res.taken && !res.mispredict |-> res.latency == 4'h1)
    else $error("not-taken latency wrong");
endmodule

bind eacbu_core eacbu_core_chk chk_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .prdata, .pready, .pslverr, .req_valid, .req, .req_ready, .res_done, .res);

// ===== bench/eacbu_pc_model.sv
/*
  Program counter of the fetch side, moved by branch results.
  Assumes results arrive as one-cycle done pulses on pclk.
*/
`timescale 1ns/1ps

module eacbu_pc_model
  import eacbu_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Result from the branch unit
  input wire logic res_done,
  input wire eacbu_res_s res,
  // Program counter
  output logic [63:0] pc
);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc <= 64'h0;
    end else if (res_done) begin
      pc <= res.next_pc;
    end
  end
endmodule

// ===== bench/ext_addr_cond_branch_unit_tb.sv
/*
  Self-checking bench of the branch unit: random branches in six
  configurations, register access over APB, queued expectations.
  Assumes the package and design files are compiled first.
*/
`timescale 1ns/1ps

module ext_addr_cond_branch_unit_tb
  import eacbu_pkg::*;
;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, req_valid = 0;
  logic pready, pslverr, req_ready, res_done, er;
  logic [7:0] paddr = 8'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [63:0] pc_m, last_pc;
  logic [1:0] ar = 2'h0, xl = 2'h0;
  eacbu_req_s req = '0;
  eacbu_res_s res, m;
  eacbu_res_s exp_q[$];
  int n_mismatch = 0, check_count = 0, cyc = 0, n_br = 0, n_tk = 0;
  // Greater-or-equal code is not ours and must pass untouched
  logic [2:0] cond_tab [4] = '{COND_GT, COND_LE, COND_LT, 3'h5};
  logic [1:0] ar_tab [6] = '{2'h0, 2'h1, 2'h2, 2'h2, 2'h3, 2'h2};
  logic [1:0] xl_tab [6] = '{2'h0, 2'h0, 2'h0, 2'h2, 2'h2, 2'h1};
  // Zero, sign and 32-bit versus long boundary values
  logic [63:0] src_tab [5] = '{64'h0, 64'h1, '1, 64'h8000_0000, 64'hffff_ffff_0000_0001};

  initial forever #25 pclk = ~pclk;

  eacbu_core dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .req_valid, .req, .req_ready, .res_done, .res);
  eacbu_pc_model pcm_u (.pclk, .presetn, .res_done, .res, .pc(pc_m));

  task automatic chk(input string n, input logic [63:0] s, input logic [63:0] x);
    check_count++;
    if (s !== x) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", n, x, s);
    end
  endtask

  task automatic conclude();
    if (n_mismatch == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  function automatic eacbu_res_s model(eacbu_req_s r);
    eacbu_res_s e;
    logic imf, lg, ds, ok;
    logic signed [63:0] v;
    logic [63:0] of;
    e = '0;
    imf = r.instr[OPC_HI:OPC_LO] == OPC_IMM_FORM;
    ds = r.instr[DS_BIT];
    lg = imf ? r.pfx_valid && r.pfx_long : r.instr[LONG_BIT];
    v = lg ? r.src_val : {{32{r.src_val[31]}}, r.src_val[31:0]};
    case (r.instr[COND_HI:COND_LO])
      COND_GT: e.taken = v > 0;
      COND_LE: e.taken = v <= 0;
      default: e.taken = v < 0;
    endcase
    of = !imf ? r.off_val : !r.pfx_valid ? {{48{r.instr[15]}}, r.instr[15:0]}
      : r.pfx_long ? {r.pfx_value, r.instr[15:0]}
      : {{32{r.pfx_value[15]}}, r.pfx_value[15:0], r.instr[15:0]};
    e.hit = (imf || r.instr[OPC_HI:OPC_LO] == OPC_REG_FORM) && r.instr[EXT_BIT] &&
      r.instr[COND_HI:COND_LO] inside {COND_GT, COND_LE, COND_LT};
    e.next_pc = e.taken ? r.pc + of : r.pc + 64'h4;
    e.delay_slot = e.taken && ds;
    e.squash_next = e.taken && !ds;
    ok = imf && r.pred_valid && r.pred_taken == e.taken;
    e.mispredict = imf && r.pred_valid && r.pred_taken != e.taken;
    if (!e.taken && !e.mispredict || ok) begin
      e.latency = 4'h1;
    end else if (ar == 2'h2) begin
      e.latency = !e.taken ? 4'h7 : (ds ? 4'h6 : 4'h7) + (!imf && xl > 1 ? 4'h2 : 4'h0);
    end else begin
      e.latency = !e.taken || !ds ? 4'h3 : 4'h2;
    end
    // Foreign instructions step on at once
    if (!e.hit) begin
      e = '0;
      e.next_pc = r.pc + 64'h4;
      e.latency = 4'h1;
    end
    return e;
  endfunction

  // Holds valid between calls; the caller drops it after a batch
  task automatic br();
    eacbu_req_s r;
    logic imf;
    r = '0;
    imf = 1'($urandom);
    r.instr = {imf ? OPC_IMM_FORM : OPC_REG_FORM, 1'($urandom), 1'b1,
      cond_tab[$urandom_range(3)], 5'h3,
      imf ? 16'($urandom) : {5'h4, 2'h0, 1'($urandom), 8'h00}};
    if ($urandom_range(15) == 0) begin
      r.instr[OPC_HI:OPC_LO] = 6'h26;
    end
    r.pc = {$urandom, $urandom};
    r.src_val = $urandom_range(5) == 5 ? {$urandom, $urandom} : src_tab[$urandom_range(4)];
    r.off_val = {$urandom, $urandom};
    if (imf) begin
      r.pfx_valid = 1'($urandom);
      r.pfx_long = 1'($urandom);
      r.pfx_value = {16'($urandom), $urandom};
      r.pred_valid = 1'($urandom);
      r.pred_taken = 1'($urandom);
    end
    m = model(r);
    exp_q.push_back(m);
    last_pc = m.next_pc;
    n_br += int'(m.hit);
    n_tk += int'(m.taken);
    req <= r;
    req_valid <= 1'b1;
    do @(posedge pclk); while (req_ready !== 1'b1);
  endtask

  always @(posedge pclk) begin
    eacbu_res_s x;
    cyc++;
    if (res_done === 1'b1) begin
      if (exp_q.size() == 0) begin
        chk("result_queue", 64'h0, 64'h1);
      end else begin
        x = exp_q.pop_front();
        chk("next_pc", res.next_pc, x.next_pc);
        chk("taken", res.taken, x.taken);
        chk("latency", res.latency, x.latency);
        chk("hit_miss", {res.hit, res.mispredict}, {x.hit, x.mispredict});
        chk("slot", {res.delay_slot, res.squash_next}, {x.delay_slot, x.squash_next});
      end
    end
    if (cyc == 5000) begin
      n_mismatch++;
      conclude();
    end
  end

  initial begin
    void'($urandom(5));
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, CTRL_ADDR, 32'h0);
    chk("ctrl_reset", rd, 64'h1);
    apb(1'b0, 8'h18, 32'h0);
    chk("unmapped", {er, rd}, 64'h1_0000_0000);
    apb(1'b1, STATUS_ADDR, 32'hffff);
    chk("status_write", er, 64'h1);
    for (int k = 0; k < 6; k++) begin
      // Area three counts as not two; level one adds nothing
      ar = ar_tab[k];
      xl = xl_tab[k];
      apb(1'b1, CTRL_ADDR, {22'h0, xl, 2'h0, ar, 4'h1});
      repeat (30) br();
      req_valid <= 1'b0;
      for (int i = 0; i < 20 && exp_q.size() > 0; i++) @(posedge pclk);
    end
    apb(1'b0, BRANCH_CNT_ADDR, 32'h0);
    chk("branch_count", rd, 64'(n_br));
    apb(1'b0, TAKEN_CNT_ADDR, 32'h0);
    chk("taken_count", rd, 64'(n_tk));
    chk("fetch_pc", pc_m, last_pc);
    chk("pending", 64'(exp_q.size()), 64'h0);
    apb(1'b0, STATUS_ADDR, 32'h0);
    chk("status", rd, {20'h0, m.latency, 3'h0, m.hit, m.mispredict, m.delay_slot, m.taken, 1'b0});
    apb(1'b0, TARGET_HI_ADDR, 32'h0);
    chk("target_hi", rd, 64'(last_pc[63:32]));
    apb(1'b0, TARGET_LO_ADDR, 32'h0);
    chk("target_lo", rd, 64'(last_pc[31:0]));
    // Disabled unit must refuse decode
    apb(1'b1, CTRL_ADDR, 32'h0);
    @(posedge pclk);
    chk("ready_off", req_ready, 64'h0);
    conclude();
  end
endmodule
